//--- core/sync_blank_pkg.sv
// constants for the blank, border and sync input stage
// assumes an APB master with 32-bit data; registers are 8 bits in the low lane
`default_nettype none
package sync_blank_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_SYNC_CONTROL = 10'h003;
  localparam logic [9:0] IDX_HSYNC_POSITION = 10'h004;
  localparam logic [9:0] IDX_POWER_MANAGEMENT = 10'h005;
  localparam logic [9:0] IDX_DAC_OPERATION = 10'h006;
  localparam logic [9:0] IDX_MISC_CONTROL_ONE = 10'h070;
  localparam logic [9:0] IDX_MISC_CONTROL_TWO = 10'h071;
  localparam logic [9:0] IDX_BORDER_RED = 10'h060;
  localparam logic [9:0] IDX_BORDER_GREEN = 10'h061;
  localparam logic [9:0] IDX_BORDER_BLUE = 10'h062;
  localparam logic [9:0] IDX_STATUS = 10'h080;
  localparam logic [9:0] IDX_SIG_LOW = 10'h081;
  localparam logic [9:0] IDX_SIG_MID = 10'h082;
  localparam logic [9:0] IDX_SIG_HIGH = 10'h083;
  // sync_control fields
  localparam int SC_HSYNC_INV = 0;
  localparam int SC_VSYNC_INV = 1;
  localparam int SC_CSYNC_INV = 2;
  localparam int SC_BYPASS = 3;
  localparam int SC_HFORCE = 4;
  localparam int SC_VFORCE = 6;
  // single-bit fields, hsync position width and reset value of the other registers
  localparam int DAC_SOG = 0;
  localparam int PM_SYNC_OFF = 0;
  localparam int M1_XOR_SYNC = 0;
  localparam int M2_INTERLACE = 0;
  localparam int M2_BYTE_PORT = 1;
  localparam int M2_SIG_ARM = 2;
  localparam int HPOS_WIDTH = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  // pixel pipeline: input sample plus output register
  localparam int PIPE_DELAY = 2;
  localparam logic [11:0] VBLANK_COUNT_MAX = 12'h800;
  typedef enum logic [1:0]
  {
    FORCE_NONE = 2'b00,
    FORCE_LOW = 2'b01,
    FORCE_HIGH = 2'b10,
    FORCE_HIZ = 2'b11
  } force_e;
  typedef enum logic [1:0]
  {
    SIG_IDLE = 2'b00,
    SIG_WAIT = 2'b01,
    SIG_RUN = 2'b10,
    SIG_DONE = 2'b11
  } sig_state_e;
endpackage
`default_nettype wire

//--- core/sync_blank_border_control.sv
// blank, border and sync input stage of a palette DAC, with APB registers
// assumes blank, border, pixel and cursor inputs are timed to CLK (load clock)
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sync_blank_border_control
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BLANK_N,
  input wire logic EDGE_VS_INTERLACE_SELECT_N,
  input wire logic [23:0] WIDE_PIXEL_PORT,
  input wire logic [7:0] BYTE_PORT,
  input wire logic CURSOR_SHOW,
  input wire logic [23:0] CURSOR_RGB,
  input wire logic HORIZ_COMPOSITE_SYNC_IN_N,
  input wire logic VERT_SYNC_IN_N,
  output logic [7:0] DAC_RED,
  output logic [7:0] DAC_GREEN,
  output logic [7:0] DAC_BLUE,
  output logic SYNC_ON_GREEN,
  output logic HORIZ_SYNC_OUT_N,
  output logic HORIZ_SYNC_OE,
  output logic VERT_SYNC_OUT_N,
  output logic VERT_SYNC_OE,
  output logic FRAME_END,
  output logic ACTIVE_AREA,
  output logic FIELD_ODD
);
  localparam int LINE_LEN = sync_blank_pkg::PIPE_DELAY + 15;

  // register file
  logic [7:0] sync_control_reg;
  logic [7:0] hsync_position_reg;
  logic [7:0] power_management_reg;
  logic [7:0] dac_operation_reg;
  logic [7:0] misc_control_one_reg;
  logic [7:0] misc_control_two_reg;
  logic [7:0] border_red_reg;
  logic [7:0] border_green_reg;
  logic [7:0] border_blue_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // sampled inputs
  logic blank_reg;
  logic border_reg;
  logic [23:0] pixel_reg;
  logic cursor_show_reg;
  logic [23:0] cursor_rgb_reg;
  logic [23:0] rgb_next;
  logic [23:0] rgb_reg;
  logic active_reg;
  logic field_reg;

  // vertical blank detection and signature
  logic [11:0] vcount_reg;
  logic [11:0] vcount_next;
  logic frame_end;
  logic frame_end_d_reg;
  logic frame_end_rise;
  sync_blank_pkg::sig_state_e sig_state_reg;
  sync_blank_pkg::sig_state_e sig_state_next;
  logic [23:0] signature_register_reg;

  // sync path
  logic [LINE_LEN-1:0] sync_line_reg;
  logic sync_src;
  logic sync_tap;
  logic hs_pre;
  logic vs_pre;
  logic sync_on_green_enable;
  logic xor_sync;
  logic bypass;
  logic interlace;
  logic sync_off;
  localparam int HPOS_W = sync_blank_pkg::HPOS_WIDTH;
  logic [HPOS_W-1:0] hpos;

  // address match against a register index
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  // output mux for a forced pin
  function automatic logic forced(input logic [1:0] mode, input logic val);
    case (mode)
      sync_blank_pkg::FORCE_LOW: forced = 1'b0;
      sync_blank_pkg::FORCE_HIGH: forced = 1'b1;
      default: forced = val;
    endcase
  endfunction

  assign sync_on_green_enable = dac_operation_reg[sync_blank_pkg::DAC_SOG];
  assign xor_sync = misc_control_one_reg[sync_blank_pkg::M1_XOR_SYNC];
  assign bypass = sync_control_reg[sync_blank_pkg::SC_BYPASS];
  assign interlace = misc_control_two_reg[sync_blank_pkg::M2_INTERLACE];
  assign sync_off = power_management_reg[sync_blank_pkg::PM_SYNC_OFF];
  assign hpos = hsync_position_reg[HPOS_W-1:0];

  // apb writes; zero wait states so a write lands on the access edge
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      sync_control_reg <= sync_blank_pkg::REG_RESET;
      hsync_position_reg <= sync_blank_pkg::REG_RESET;
      power_management_reg <= sync_blank_pkg::REG_RESET;
      dac_operation_reg <= sync_blank_pkg::REG_RESET;
      misc_control_one_reg <= sync_blank_pkg::REG_RESET;
      misc_control_two_reg <= sync_blank_pkg::REG_RESET;
      border_red_reg <= sync_blank_pkg::REG_RESET;
      border_green_reg <= sync_blank_pkg::REG_RESET;
      border_blue_reg <= sync_blank_pkg::REG_RESET;
    end
    else if (PSEL && PENABLE && PWRITE)
    begin
      if (hit(PADDR, sync_blank_pkg::IDX_SYNC_CONTROL))
        sync_control_reg <= PWDATA[7:0];
      if (hit(PADDR, sync_blank_pkg::IDX_HSYNC_POSITION))
        hsync_position_reg <= PWDATA[7:0];
      if (hit(PADDR, sync_blank_pkg::IDX_POWER_MANAGEMENT))
        power_management_reg <= PWDATA[7:0];
      if (hit(PADDR, sync_blank_pkg::IDX_DAC_OPERATION))
        dac_operation_reg <= PWDATA[7:0];
      if (hit(PADDR, sync_blank_pkg::IDX_MISC_CONTROL_ONE))
        misc_control_one_reg <= PWDATA[7:0];
      if (hit(PADDR, sync_blank_pkg::IDX_MISC_CONTROL_TWO))
        misc_control_two_reg <= PWDATA[7:0];
      if (hit(PADDR, sync_blank_pkg::IDX_BORDER_RED))
        border_red_reg <= PWDATA[7:0];
      if (hit(PADDR, sync_blank_pkg::IDX_BORDER_GREEN))
        border_green_reg <= PWDATA[7:0];
      if (hit(PADDR, sync_blank_pkg::IDX_BORDER_BLUE))
        border_blue_reg <= PWDATA[7:0];
    end
  end

  // read data captured in the setup cycle, so prdata comes from a flop
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (PSEL && !PENABLE)
    begin
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      if (hit(PADDR, sync_blank_pkg::IDX_SYNC_CONTROL))
        prdata_reg[7:0] <= sync_control_reg;
      else if (hit(PADDR, sync_blank_pkg::IDX_HSYNC_POSITION))
        prdata_reg[7:0] <= hsync_position_reg;
      else if (hit(PADDR, sync_blank_pkg::IDX_POWER_MANAGEMENT))
        prdata_reg[7:0] <= power_management_reg;
      else if (hit(PADDR, sync_blank_pkg::IDX_DAC_OPERATION))
        prdata_reg[7:0] <= dac_operation_reg;
      else if (hit(PADDR, sync_blank_pkg::IDX_MISC_CONTROL_ONE))
        prdata_reg[7:0] <= misc_control_one_reg;
      else if (hit(PADDR, sync_blank_pkg::IDX_MISC_CONTROL_TWO))
        prdata_reg[7:0] <= misc_control_two_reg;
      else if (hit(PADDR, sync_blank_pkg::IDX_BORDER_RED))
        prdata_reg[7:0] <= border_red_reg;
      else if (hit(PADDR, sync_blank_pkg::IDX_BORDER_GREEN))
        prdata_reg[7:0] <= border_green_reg;
      else if (hit(PADDR, sync_blank_pkg::IDX_BORDER_BLUE))
        prdata_reg[7:0] <= border_blue_reg;
      else if (hit(PADDR, sync_blank_pkg::IDX_STATUS))
        prdata_reg[3:0] <= {sig_state_reg, active_reg, frame_end};
      else if (hit(PADDR, sync_blank_pkg::IDX_SIG_LOW))
        prdata_reg[7:0] <= signature_register_reg[7:0];
      else if (hit(PADDR, sync_blank_pkg::IDX_SIG_MID))
        prdata_reg[7:0] <= signature_register_reg[15:8];
      else if (hit(PADDR, sync_blank_pkg::IDX_SIG_HIGH))
        prdata_reg[7:0] <= signature_register_reg[23:16];
      else
        pslverr_reg <= 1'b1; // unmapped index
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = pslverr_reg && PSEL && PENABLE;

  // first pipeline stage: latch controls and data on the load clock
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      blank_reg <= 1'b0;
      border_reg <= 1'b0;
      pixel_reg <= 24'h00_0000;
      cursor_show_reg <= 1'b0;
      cursor_rgb_reg <= 24'h00_0000;
    end
    else
    begin
      blank_reg <= BLANK_N;
      border_reg <= EDGE_VS_INTERLACE_SELECT_N;
      if (misc_control_two_reg[sync_blank_pkg::M2_BYTE_PORT])
        pixel_reg <= {3{BYTE_PORT}};
      else
        pixel_reg <= WIDE_PIXEL_PORT;
      cursor_show_reg <= CURSOR_SHOW;
      cursor_rgb_reg <= CURSOR_RGB;
    end
  end

  // colour select in priority order: blanking, border unless interlaced, cursor, pixel
  always_comb
  begin
    if (!blank_reg)
      rgb_next = 24'h00_0000;
    else if (!interlace && !border_reg)
      rgb_next = {border_red_reg, border_green_reg, border_blue_reg};
    else if (cursor_show_reg)
      rgb_next = cursor_rgb_reg;
    else
      rgb_next = pixel_reg;
  end

  // second stage: output register and area flags
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      rgb_reg <= 24'h00_0000;
      active_reg <= 1'b0;
      field_reg <= 1'b0;
    end
    else
    begin
      rgb_reg <= rgb_next;
      active_reg <= blank_reg && (interlace || border_reg);
      field_reg <= interlace && border_reg;
    end
  end

  assign DAC_RED = rgb_reg[23:16];
  assign DAC_GREEN = rgb_reg[15:8];
  assign DAC_BLUE = rgb_reg[7:0];
  assign ACTIVE_AREA = active_reg;
  assign FIELD_ODD = field_reg;

  // pixel count inside blanking, saturating at the end-of-frame count
  always_comb
  begin
    if (blank_reg)
      vcount_next = 12'h000;
    else if (vcount_reg == sync_blank_pkg::VBLANK_COUNT_MAX)
      vcount_next = vcount_reg;
    else
      vcount_next = vcount_reg + 12'h001;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      vcount_reg <= 12'h000;
      frame_end_d_reg <= 1'b0;
    end
    else
    begin
      vcount_reg <= vcount_next;
      frame_end_d_reg <= frame_end;
    end
  end

  // held until the counter clears when blanking ends
  assign frame_end = (vcount_reg == sync_blank_pkg::VBLANK_COUNT_MAX);
  assign frame_end_rise = frame_end && !frame_end_d_reg;
  assign FRAME_END = frame_end;

  // signature arms, waits for a frame end, runs one frame, then holds
  always_comb
  begin
    sig_state_next = sig_state_reg;
    case (sig_state_reg)
      sync_blank_pkg::SIG_IDLE:
        if (misc_control_two_reg[sync_blank_pkg::M2_SIG_ARM])
          sig_state_next = sync_blank_pkg::SIG_WAIT;
      sync_blank_pkg::SIG_WAIT:
        if (frame_end_rise)
          sig_state_next = sync_blank_pkg::SIG_RUN;
      sync_blank_pkg::SIG_RUN:
        if (frame_end_rise)
          sig_state_next = sync_blank_pkg::SIG_DONE;
      default:
        sig_state_next = sig_state_reg;
    endcase
    if (!misc_control_two_reg[sync_blank_pkg::M2_SIG_ARM])
      sig_state_next = sync_blank_pkg::SIG_IDLE;
  end

  // border pixels count too, since only blanking gates the accumulation
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      sig_state_reg <= sync_blank_pkg::SIG_IDLE;
      signature_register_reg <= 24'h00_0000;
    end
    else
    begin
      sig_state_reg <= sig_state_next;
      if (sig_state_reg == sync_blank_pkg::SIG_WAIT)
        signature_register_reg <= 24'h00_0000;
      else if (sig_state_reg == sync_blank_pkg::SIG_RUN && blank_reg)
        signature_register_reg <= {signature_register_reg[22:0],
          signature_register_reg[23] ^ signature_register_reg[22]} ^ rgb_next;
    end
  end

  // sync delay line; the one source picks synthetic or received sync
  assign sync_src = xor_sync ? (HORIZ_COMPOSITE_SYNC_IN_N ^ VERT_SYNC_IN_N)
                             : HORIZ_COMPOSITE_SYNC_IN_N;

  // power bit freezes the line rather than gating a clock
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      sync_line_reg <= {LINE_LEN{1'b1}};
    else if (!sync_off)
      sync_line_reg <= {sync_line_reg[LINE_LEN-2:0], sync_src};
  end

  // tap matches the two pixel stages plus the position offset
  assign sync_tap = sync_line_reg[(sync_blank_pkg::PIPE_DELAY - 1) + int'(hpos)];

  // green injection while composite sync is low
  assign SYNC_ON_GREEN = sync_on_green_enable && !(sync_tap ^ sync_control_reg[sync_blank_pkg::SC_CSYNC_INV]);

  // hsync source; raw pin paths bypass the sampler on purpose
  always_comb
  begin
    if (sync_on_green_enable)
      hs_pre = HORIZ_COMPOSITE_SYNC_IN_N;
    else if (xor_sync)
      hs_pre = sync_tap;
    else if (bypass)
      hs_pre = HORIZ_COMPOSITE_SYNC_IN_N;
    else
      hs_pre = sync_tap;
    hs_pre = hs_pre ^ sync_control_reg[sync_blank_pkg::SC_HSYNC_INV];
  end

  assign vs_pre = VERT_SYNC_IN_N ^ sync_control_reg[sync_blank_pkg::SC_VSYNC_INV];

  // force and high-impedance controls per pin
  assign HORIZ_SYNC_OUT_N = forced(sync_control_reg[sync_blank_pkg::SC_HFORCE +: 2], hs_pre);
  assign HORIZ_SYNC_OE = (sync_control_reg[sync_blank_pkg::SC_HFORCE +: 2] != sync_blank_pkg::FORCE_HIZ);
  assign VERT_SYNC_OUT_N = forced(sync_control_reg[sync_blank_pkg::SC_VFORCE +: 2], vs_pre);
  assign VERT_SYNC_OE = (sync_control_reg[sync_blank_pkg::SC_VFORCE +: 2] != sync_blank_pkg::FORCE_HIZ);

  // configuration held steady long enough for the two-cycle sync delay
  sequence sync_cfg_steady(logic mode_sog);
    (sync_on_green_enable == mode_sog && xor_sync && hpos == '0 && !sync_off)[*3];
  endsequence

  a_blank_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    !blank_reg |=> rgb_reg == 24'h00_0000) else $error("blanked pixel not zero");
  a_border_color: assert property (@(posedge CLK) disable iff (!RSTN)
    blank_reg && !border_reg && !interlace |=> DAC_RED == $past(border_red_reg))
    else $error("border colour not shown");
  a_interlace_noborder: assert property (@(posedge CLK) disable iff (!RSTN)
    blank_reg && interlace && !cursor_show_reg |=> rgb_reg == $past(pixel_reg))
    else $error("border shown in interlace use");
  a_frame_end_count: assert property (@(posedge CLK) disable iff (!RSTN)
    !blank_reg && vcount_reg == 12'h7ff ##1 !blank_reg |=> frame_end)
    else $error("end of frame missed at count");
  a_count_clear: assert property (@(posedge CLK) disable iff (!RSTN)
    blank_reg |=> vcount_reg == 12'h000 && !frame_end) else $error("counter not cleared");
  a_sig_one_frame: assert property (@(posedge CLK) disable iff (!RSTN)
    sig_state_reg == sync_blank_pkg::SIG_RUN && frame_end_rise
      && misc_control_two_reg[sync_blank_pkg::M2_SIG_ARM]
    |=> sig_state_reg == sync_blank_pkg::SIG_DONE) else $error("signature not bounded");
  a_green_inject: assert property (@(posedge CLK) disable iff (!RSTN)
    sync_cfg_steady(1'b1) |-> SYNC_ON_GREEN ==
      !($past(HORIZ_COMPOSITE_SYNC_IN_N ^ VERT_SYNC_IN_N, 2)
        ^ sync_control_reg[sync_blank_pkg::SC_CSYNC_INV]))
    else $error("green sync wrong or misaligned");
  a_xor_on_hsync: assert property (@(posedge CLK) disable iff (!RSTN)
    sync_cfg_steady(1'b0) |-> !SYNC_ON_GREEN && hs_pre ==
      ($past(HORIZ_COMPOSITE_SYNC_IN_N ^ VERT_SYNC_IN_N, 2)
        ^ sync_control_reg[sync_blank_pkg::SC_HSYNC_INV]))
    else $error("synthetic sync not on hsync");
  a_hsync_bypass: assert property (@(posedge CLK) disable iff (!RSTN)
    bypass && !sync_on_green_enable && !xor_sync && sync_control_reg[5:4] == 2'b00
    |-> HORIZ_SYNC_OUT_N == (HORIZ_COMPOSITE_SYNC_IN_N ^ sync_control_reg[0]))
    else $error("hsync bypass not direct");
  a_vsync_direct: assert property (@(posedge CLK) disable iff (!RSTN)
    sync_control_reg[7:6] == 2'b00
    |-> VERT_SYNC_OUT_N == (VERT_SYNC_IN_N ^ sync_control_reg[1]) && VERT_SYNC_OE)
    else $error("vsync not passed through");
endmodule // sync_blank_border_control
`default_nettype wire

//--- tb/video_controller_model.sv
// controller model: drives blanking and the shared border or field strobe
// assumes the bench sets the request levels by non-blocking assignment at a rising edge
`timescale 1ns/1ns
`default_nettype none
module video_controller_model
(
  input wire logic blank_on,
  input wire logic border_on,
  input wire logic interlace,
  input wire logic field,
  output logic blank_n,
  output logic strobe_n
);
  // strobe held active across blanking unless interlaced, where it carries the field; border asked for only on whole lines, never mid-line
  assign blank_n = ~blank_on;
  assign strobe_n = interlace ? field : ~(blank_on | border_on);
endmodule // video_controller_model
`default_nettype wire

//--- tb/sync_blank_border_control_tb_top.sv
// self-checking bench: APB register access, pixel gating, frame end and sync routing
// assumes the design in core/ and the controller model in tb/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module sync_blank_border_control_tb_top;
  localparam logic [9:0] SC = sync_blank_pkg::IDX_SYNC_CONTROL;
  localparam logic [9:0] HP = sync_blank_pkg::IDX_HSYNC_POSITION;
  localparam logic [9:0] DO = sync_blank_pkg::IDX_DAC_OPERATION;
  localparam logic [9:0] M1 = sync_blank_pkg::IDX_MISC_CONTROL_ONE;
  localparam logic [9:0] M2 = sync_blank_pkg::IDX_MISC_CONTROL_TWO;
  logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic BLANK_N, STROBE_N, CURSOR_SHOW, HS_N, VS_N, SYNC_ON_GREEN_ENABLE, HS_OUT_N, HS_OE, VS_OUT_N, VS_OE;
  logic FRAME_END, ACTIVE_AREA, FIELD_ODD;
  logic [23:0] PIX, CURSOR_RGB;
  logic [7:0] BYTE_PORT, DAC_RED, DAC_GREEN, DAC_BLUE;
  logic blank_on, border_on, interlace, field, err;
  logic [31:0] rd;
  logic [9:0] regs [5];
  int mismatches, num_checks;

  // load clock, 100 ns period
  initial
  begin
    CLK = 1'h0;
    forever #50 CLK = ~CLK;
  end

  sync_blank_border_control dut
  (
    .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BLANK_N(BLANK_N),
    .EDGE_VS_INTERLACE_SELECT_N(STROBE_N), .WIDE_PIXEL_PORT(PIX), .BYTE_PORT(BYTE_PORT),
    .CURSOR_SHOW(CURSOR_SHOW), .CURSOR_RGB(CURSOR_RGB), .HORIZ_COMPOSITE_SYNC_IN_N(HS_N),
    .VERT_SYNC_IN_N(VS_N), .DAC_RED(DAC_RED), .DAC_GREEN(DAC_GREEN), .DAC_BLUE(DAC_BLUE),
    .SYNC_ON_GREEN(SYNC_ON_GREEN_ENABLE), .HORIZ_SYNC_OUT_N(HS_OUT_N), .HORIZ_SYNC_OE(HS_OE),
    .VERT_SYNC_OUT_N(VS_OUT_N), .VERT_SYNC_OE(VS_OE), .FRAME_END(FRAME_END),
    .ACTIVE_AREA(ACTIVE_AREA), .FIELD_ODD(FIELD_ODD)
  );

  video_controller_model ctrl
  (
    .blank_on(blank_on), .border_on(border_on), .interlace(interlace), .field(field),
    .blank_n(BLANK_N), .strobe_n(STROBE_N)
  );

  task summarize;
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one APB transfer; read data and error taken at the edge that samples pready high
  task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= {idx, 2'h0};
    PWDATA <= {24'h00_0000, d};
    @(posedge CLK);
    PENABLE <= 1'h1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge CLK);
      if (PREADY === 1'h1)
      begin
        rd = PRDATA;
        err = PSLVERR;
        break;
      end
    end
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    if (n == 16)
    begin
      mismatches++;
      summarize();
    end
  endtask

  // wait n edges, then look once the edge's updates have landed
  task settle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // set video controls at an edge; outputs appear one edge after sampling
  task vid(input logic bl, input logic bo, input logic cu);
    @(posedge CLK);
    blank_on <= bl;
    border_on <= bo;
    CURSOR_SHOW <= cu;
    settle(3);
  endtask

  task pins(input logic h, input logic v);
    @(posedge CLK);
    HS_N <= h;
    VS_N <= v;
    #1;
  endtask

  initial
  begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, interlace, field, CURSOR_SHOW, border_on} = '0;
    {RSTN, blank_on} = '0;
    HS_N = 1'h1;
    VS_N = 1'h1;
    PIX = 24'h12_3456;
    CURSOR_RGB = 24'h65_4321;
    BYTE_PORT = 8'h5a;
    regs = '{SC, HP, sync_blank_pkg::IDX_POWER_MANAGEMENT, DO, M1};
    repeat (4) @(posedge CLK);
    RSTN <= 1'h1;
    // register table: reset zero, full read-write, unmapped refused
    foreach (regs[i])
    begin
      apb(1'h0, regs[i], 8'h00);
      `CHK("reg reset", 32'h0000_0000, rd)
      apb(1'h1, regs[i], 8'ha5);
      apb(1'h0, regs[i], 8'h00);
      `CHK("reg rw", 32'h0000_00a5, rd)
      apb(1'h1, regs[i], 8'h00);
    end
    apb(1'h0, 10'h3ff, 8'h00);
    `CHK("unmapped err", 1'h1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    apb(1'h1, sync_blank_pkg::IDX_BORDER_RED, 8'h11);
    apb(1'h1, sync_blank_pkg::IDX_BORDER_GREEN, 8'h22);
    apb(1'h1, sync_blank_pkg::IDX_BORDER_BLUE, 8'h33);
    // pixel gating: blank, pixel, cursor, border, interlace
    vid(1'h1, 1'h0, 1'h1);
    `CHK("blank dac", 24'h00_0000, {DAC_RED, DAC_GREEN, DAC_BLUE})
    vid(1'h0, 1'h0, 1'h0);
    `CHK("pixel dac", 24'h12_3456, {DAC_RED, DAC_GREEN, DAC_BLUE})
    `CHK("active", 1'h1, ACTIVE_AREA)
    // byte port stays selected through cursor and border; cleared by the interlace write
    apb(1'h1, M2, 8'h02);
    vid(1'h0, 1'h0, 1'h0);
    `CHK("byte port dac", 24'h5a_5a5a, {DAC_RED, DAC_GREEN, DAC_BLUE})
    vid(1'h0, 1'h0, 1'h1);
    `CHK("cursor dac", 24'h65_4321, {DAC_RED, DAC_GREEN, DAC_BLUE})
    vid(1'h0, 1'h1, 1'h1);
    `CHK("border dac", 24'h11_2233, {DAC_RED, DAC_GREEN, DAC_BLUE})
    `CHK("border inactive", 1'h0, ACTIVE_AREA)
    apb(1'h1, M2, 8'h01);
    interlace <= 1'h1;
    vid(1'h0, 1'h1, 1'h0);
    `CHK("intl dac", 24'h12_3456, {DAC_RED, DAC_GREEN, DAC_BLUE})
    `CHK("field low", 1'h0, FIELD_ODD)
    @(posedge CLK);
    field <= 1'h1;
    settle(3);
    `CHK("field high", 1'h1, FIELD_ODD)
    apb(1'h1, M2, 8'h04);
    interlace <= 1'h0;
    // vertical blank detection, and counter cleared by a short stretch of active video between blanks
    vid(1'h1, 1'h0, 1'h0);
    settle(2045);
    `CHK("frame end early", 1'h0, FRAME_END)
    settle(1);
    `CHK("frame end", 1'h1, FRAME_END)
    vid(1'h0, 1'h0, 1'h0);
    `CHK("frame end clear", 1'h0, FRAME_END)
    vid(1'h1, 1'h0, 1'h0);
    settle(1000);
    vid(1'h0, 1'h0, 1'h0);
    vid(1'h1, 1'h0, 1'h0);
    settle(1100);
    `CHK("count restart", 1'h0, FRAME_END)
    settle(1000);
    `CHK("frame end again", 1'h1, FRAME_END)
    vid(1'h0, 1'h0, 1'h0);
    // signature armed before the first frame end, so two frame ends leave it done
    apb(1'h0, sync_blank_pkg::IDX_STATUS, 8'h00);
    `CHK("sig done status", 32'h0000_000e, rd)
    apb(1'h1, M2, 8'h00);
    // vsync: pass, invert, force low, force high, high impedance; seen before any edge
    for (int i = 0; i < 5; i++)
      for (int p = 0; p < 2; p++)
      begin
        apb(1'h1, SC, (i == 0) ? 8'h00 : (i == 1) ? 8'h02 : 8'h00 + 8'h40 * (i - 1));
        pins(1'h1, p[0]);
        if (i < 4)
          `CHK("vsync", (i == 0) ? p[0] : (i == 1) ? ~p[0] : (i == 3), VS_OUT_N)
        `CHK("vsync oe", (i != 4), VS_OE)
      end
    // hsync bypass straight through, then inverted
    apb(1'h1, SC, 8'h08);
    pins(1'h0, 1'h1);
    `CHK("hs bypass", 1'h0, HS_OUT_N)
    apb(1'h1, SC, 8'h09);
    pins(1'h1, 1'h1);
    `CHK("hs bypass inv", 1'h0, HS_OUT_N)
    apb(1'h1, SC, 8'h18);
    settle(0);
    `CHK("hs force low", 1'h0, HS_OUT_N)
    `CHK("hs oe", 1'h1, HS_OE)
    apb(1'h1, SC, 8'h38);
    settle(0);
    `CHK("hs hiz oe", 1'h0, HS_OE)
    // latched hsync: pipeline of two plus position of three
    apb(1'h1, SC, 8'h00);
    apb(1'h1, HP, 8'h03);
    pins(1'h0, 1'h1);
    settle(4);
    `CHK("hs delayed old", 1'h1, HS_OUT_N)
    settle(1);
    `CHK("hs delayed new", 1'h0, HS_OUT_N)
    // synthetic sync on hsync out, green left clean
    apb(1'h1, HP, 8'h00);
    apb(1'h1, M1, 8'h01);
    pins(1'h1, 1'h0);
    settle(4);
    `CHK("xor differ", 1'h1, HS_OUT_N)
    `CHK("xor no green", 1'h0, SYNC_ON_GREEN_ENABLE)
    pins(1'h1, 1'h1);
    settle(4);
    `CHK("xor same", 1'h0, HS_OUT_N)
    // composite sync on green, hsync out raw; synthetic sync off
    apb(1'h1, M1, 8'h00);
    apb(1'h1, DO, 8'h01);
    pins(1'h0, 1'h1);
    `CHK("sog raw hs", 1'h0, HS_OUT_N)
    settle(4);
    `CHK("sog inject", 1'h1, SYNC_ON_GREEN_ENABLE)
    pins(1'h1, 1'h1);
    `CHK("sog raw hs high", 1'h1, HS_OUT_N)
    settle(4);
    `CHK("sog idle", 1'h0, SYNC_ON_GREEN_ENABLE)
    // synthetic sync onto green: equal pins give low composite, so green is injected
    apb(1'h1, M1, 8'h01);
    settle(4);
    `CHK("sog xor low", 1'h1, SYNC_ON_GREEN_ENABLE)
    pins(1'h1, 1'h0);
    `CHK("sog xor delay", 1'h1, SYNC_ON_GREEN_ENABLE)
    `CHK("sog xor raw hs", 1'h1, HS_OUT_N)
    settle(4);
    `CHK("sog xor high", 1'h0, SYNC_ON_GREEN_ENABLE)
    summarize();
  end
endmodule // sync_blank_border_control_tb_top
`default_nettype wire
